// file: design/crc_scratch_pkg.sv
// Purpose: constants shared by the section 3 scratch and check register bank
// Assumes: 16-bit register words, 8-bit register addresses from the serial port
// Notes: all offsets, reset values and field positions live here
package crc_scratch_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam logic [7:0] OFS_SCRATCH_A = 8'hE1;
   localparam logic [7:0] OFS_SCRATCH_B = 8'hE2;
   localparam logic [7:0] OFS_SCRATCH_C = 8'hE3;
   localparam logic [7:0] OFS_CHECK = 8'hFE;
   localparam logic [15:0] RST_SCRATCH_A = 16'h0000;
   localparam logic [15:0] RST_SCRATCH_B = 16'h0000;
   localparam logic [15:0] RST_SCRATCH_C = 16'h0000;
   localparam logic [15:0] RST_CHECK = 16'h0000;
   // writable-bit masks; zero bits are reserved and read as zero
   localparam logic [15:0] MASK_SCRATCH_A = 16'hFFFF;
   localparam logic [15:0] MASK_SCRATCH_B = 16'hFF00;
   localparam logic [15:0] MASK_SCRATCH_C = 16'hFFFF;
   localparam logic [15:0] MASK_CHECK = 16'hFFFF;
   localparam int NUM_REGS = 4;
   typedef enum logic [1:0] {REG_A, REG_B, REG_C, REG_CHK} reg_sel_t;
endpackage

// file: design/reg_access_if.sv
`timescale 1ns/1ps
// Purpose: carries one register access from the serial front end to storage
// Assumes: single clock, write strobe one cycle wide
// Notes: read data is combinational from storage
interface reg_access_if;
   import crc_scratch_pkg::*;
   logic wr_stb;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic [DATA_W-1:0] rdata;
   modport master (output wr_stb, output addr, output wdata, input rdata);
   modport slave (input wr_stb, input addr, input wdata, output rdata);
endinterface

// file: design/scratch_store.sv
`timescale 1ns/1ps
// Purpose: the four sixteen-bit registers with reserved-bit masking
// Assumes: addr decoded here, unmapped addresses read zero
// Notes: check word feeds the section 3 check; all four words also read back
module scratch_store
   import crc_scratch_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // access
   reg_access_if.slave acc,
   // contents for the integrity check
   output logic [DATA_W-1:0] check_value
);
   localparam logic [7:0] OFS [NUM_REGS] = '{OFS_SCRATCH_A, OFS_SCRATCH_B, OFS_SCRATCH_C,
                                             OFS_CHECK};
   localparam logic [15:0] RST [NUM_REGS] = '{RST_SCRATCH_A, RST_SCRATCH_B, RST_SCRATCH_C,
                                             RST_CHECK};
   localparam logic [15:0] MSK [NUM_REGS] = '{MASK_SCRATCH_A, MASK_SCRATCH_B, MASK_SCRATCH_C,
                                             MASK_CHECK};
   logic [DATA_W-1:0] store [NUM_REGS];
   logic [DATA_W-1:0] hit_data [NUM_REGS];

   genvar i;
   generate
      for (i = 0; i < NUM_REGS; i++) begin : g_reg
         always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
               store[i] <= RST[i];
            end else if (acc.wr_stb && acc.addr == OFS[i]) begin
               // reserved positions stay at zero whatever is written
               store[i] <= acc.wdata & MSK[i];
            end
         end
         assign hit_data[i] = (acc.addr == OFS[i]) ? (store[i] & MSK[i]) : 16'h0000;
      end
   endgenerate

   always_comb begin
      acc.rdata = 16'h0000;
      for (int k = 0; k < NUM_REGS; k++) begin
         acc.rdata = acc.rdata | hit_data[k];
      end
   end

   assign check_value = store[REG_CHK];
endmodule // scratch_store

// file: design/crc_scratch_register_bank.sv
`timescale 1ns/1ps
// Purpose: serial-port register bank tail: three scratch words and check value
// Assumes: serial pins synchronous to clk_sys, mode 0, MSB first, 32-bit frames
// Notes: frame = rw bit, 7 pad bits, 8 address bits, 16 data bits; pin reset ANDs in
module crc_scratch_register_bank
   import crc_scratch_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic hw_reset_pin_n,
   // serial port
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic sdi,
   output logic sdo,
   // converter result events
   input wire logic conv_done_a,
   input wire logic conv_done_b,
   input wire logic result_read,
   output logic data_ready_pin_n,
   // stored check value
   output logic [DATA_W-1:0] section3_expected_check
);
   typedef enum logic [1:0] {IDLE, ADDR, DATA} phase_t;
   // address complete after 16 rises; counter wraps to zero after the 32nd rise
   localparam logic [4:0] ADDR_END = 5'd16;
   localparam logic [4:0] LAST_BIT = 5'd31;

   logic rst_n;
   phase_t phase;
   logic sclk_q;
   logic [4:0] bit_cnt;
   logic [7:0] cmd_sh;
   logic [15:0] data_sh;
   logic [15:0] out_sh;
   logic is_read;
   logic rise;
   logic fall;
   logic ready;

   reg_access_if acc ();

   // pin reset reaches every flop, same as power-on
   assign rst_n = nrst & hw_reset_pin_n;
   assign rise = sclk & ~sclk_q & ~cs_n;
   assign fall = ~sclk & sclk_q & ~cs_n;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sclk_q <= 1'b0;
      end else begin
         sclk_q <= sclk;
      end
   end

   // frame phase; chip select high always aborts, so host must release it
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         phase <= IDLE;
         bit_cnt <= 5'd0;
      end else if (cs_n) begin
         phase <= IDLE;
         bit_cnt <= 5'd0;
      end else if (rise) begin
         bit_cnt <= bit_cnt + 5'd1;
         case (phase)
            IDLE: phase <= ADDR;
            ADDR: phase <= (bit_cnt == ADDR_END - 5'd1) ? DATA : ADDR;
            DATA: phase <= (bit_cnt == LAST_BIT) ? IDLE : DATA;
            default: phase <= IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cmd_sh <= 8'h00;
         data_sh <= 16'h0000;
         is_read <= 1'b0;
      end else if (rise) begin
         if (bit_cnt < ADDR_END) begin
            cmd_sh <= {cmd_sh[6:0], sdi};
            if (bit_cnt == 5'd0) begin
               is_read <= sdi;
            end
         end else begin
            data_sh <= {data_sh[14:0], sdi};
         end
      end
   end

   // second byte carries the address; first byte bit7 = read
   always_comb begin
      acc.wr_stb = 1'b0;
      acc.addr = (bit_cnt == ADDR_END - 5'd1) ? {cmd_sh[6:0], sdi} : cmd_sh;
      acc.wdata = {data_sh[14:0], sdi};
      if (rise && bit_cnt == LAST_BIT && !is_read) begin
         acc.wr_stb = 1'b1;
         acc.addr = cmd_sh;
      end
   end

   // read data loaded when address byte completes, shifted on falling edge
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         out_sh <= 16'h0000;
         sdo <= 1'b0;
      end else if (rise && bit_cnt == ADDR_END - 5'd1) begin
         out_sh <= acc.rdata;
      end else if (fall && phase == DATA) begin
         sdo <= out_sh[15];
         out_sh <= {out_sh[14:0], 1'b0};
      end
   end

   scratch_store u_store (
      .clk_sys(clk_sys),
      .nrst(rst_n),
      .acc(acc.slave),
      .check_value(section3_expected_check)
   );

   // either converter finishing raises ready; reading results drops it unless a converter also finishes that cycle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ready <= 1'b0;
      end else if (conv_done_a || conv_done_b) begin
         ready <= 1'b1;
      end else if (result_read) begin
         ready <= 1'b0;
      end
   end

   assign data_ready_pin_n = ~ready;
endmodule // crc_scratch_register_bank

// file: dv/crc_scratch_monitor.sv
// Purpose: pin assertions for the bank
// Assumes: one clock
// Notes: bound below
`timescale 1ns/1ps
module crc_scratch_monitor
   import crc_scratch_pkg::*;
(
   // clock, resets
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic hw_reset_pin_n,
   // pins
   input wire logic cs_n,
   input wire logic conv_done_a,
   input wire logic conv_done_b,
   input wire logic result_read,
   input wire logic data_ready_pin_n,
   input wire logic [DATA_W-1:0] section3_expected_check
);
   wire logic [15:0] chk = section3_expected_check;
   wire logic rdy_n = data_ready_pin_n;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!(nrst && hw_reset_pin_n));
   property p_rc; disable iff (!nrst) !hw_reset_pin_n |-> chk == 16'h0000; endproperty
   a_rc: assert property (p_rc) else $error("chk in rst");
   property p_rr; disable iff (!nrst) !hw_reset_pin_n |-> rdy_n; endproperty
   a_rr: assert property (p_rr) else $error("rdy in rst");
   property p_sa; conv_done_a |=> !rdy_n; endproperty
   a_sa: assert property (p_sa) else $error("set a");
   property p_sb; conv_done_b |=> !rdy_n; endproperty
   a_sb: assert property (p_sb) else $error("set b");
   property p_cl; result_read && !conv_done_a && !conv_done_b |=> rdy_n; endproperty
   a_cl: assert property (p_cl) else $error("clear");
   property p_fa; $fell(rdy_n) |-> $past(conv_done_a || conv_done_b); endproperty
   a_fa: assert property (p_fa) else $error("rdy cause");
   property p_ri; $rose(rdy_n) |-> $past(result_read); endproperty
   a_ri: assert property (p_ri) else $error("rdy lost");
   property p_id; cs_n [*2] |=> $stable(chk); endproperty
   a_id: assert property (p_id) else $error("chk idle");
   c_both: cover property (conv_done_a && result_read);
   c_wr: cover property ($changed(chk));
   c_hw: cover property (disable iff (!nrst) !hw_reset_pin_n);
endmodule // crc_scratch_monitor
bind crc_scratch_register_bank crc_scratch_monitor crc_scratch_monitor_inst (.clk_sys, .nrst,
   .hw_reset_pin_n, .cs_n, .conv_done_a, .conv_done_b, .result_read, .data_ready_pin_n,
   .section3_expected_check);

// file: dv/spi_host.sv
// Purpose: serial host model
// Assumes: mode 0, msb first, 32-bit frames
// Notes: sclk parks low, sdi flips between frames
`timescale 1ns/1ps
module spi_host (
   // clock
   input wire logic clk_sys,
   // serial lines
   output logic cs_n = 1'b1,
   output logic sclk = 1'b0,
   output logic sdi = 1'b0,
   input wire logic sdo
);
   task automatic xfer(input logic [31:0] f, input int nb, output logic [15:0] rv);
      @(posedge clk_sys) cs_n <= 1'b0;
      for (int i = 0; i < nb; i++) begin
         sdi <= f[31-i];
         repeat (2) @(posedge clk_sys);
         @(negedge clk_sys) rv = {rv[14:0], sdo};
         @(posedge clk_sys) sclk <= 1'b1;
         repeat (2) @(posedge clk_sys);
         sclk <= 1'b0;
      end
      repeat (3) @(posedge clk_sys);
      cs_n <= 1'b1;
      sdi <= ~sdi;
      repeat (2) @(posedge clk_sys);
   endtask
endmodule // spi_host

// file: dv/crc_scratch_register_bank_tb.sv
// Purpose: self-checking bench
// Assumes: host model frames
// Notes: seed fixed
`timescale 1ns/1ps
module crc_scratch_register_bank_tb;
   logic clk_sys = 1'b0, nrst = 1'b0, hw_reset_pin_n = 1'b1, rdy = 1'b0;
   logic conv_done_a = 1'b0, conv_done_b = 1'b0, result_read = 1'b0;
   logic cs_n, sclk, sdi, sdo, data_ready_pin_n;
   logic [15:0] section3_expected_check, rv;
   logic [31:0] seed = 32'h00000056;
   logic [7:0] adr [5] = '{8'hE1, 8'hE2, 8'hE3, 8'hFE, 8'hE4};
   logic [15:0] msk [5] = '{16'hFFFF, 16'hFF00, 16'hFFFF, 16'hFFFF, 16'h0000};
   int bad_count = 0, checks_done = 0, cyc = 0;
   always #50 clk_sys = ~clk_sys;
   spi_host spi_host_inst (.clk_sys, .cs_n, .sclk, .sdi, .sdo);
   crc_scratch_register_bank crc_scratch_register_bank_inst (.clk_sys, .nrst, .hw_reset_pin_n,
      .cs_n, .sclk, .sdi, .sdo, .conv_done_a, .conv_done_b, .result_read, .data_ready_pin_n,
      .section3_expected_check);
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      return s ^ (s << 5);
   endfunction
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clk_sys) if (++cyc == 20000) begin
      bad_count++;
      final_report;
   end
   initial begin
      repeat (8) @(posedge clk_sys);
      nrst <= 1'b1;
      // first lap reads reset values, later laps write then read back
      for (int i = 0; i < 20; i++) begin
         seed = xs(seed);
         if (i >= 5) spi_host_inst.xfer({8'h00, adr[i % 5], seed[15:0]}, 32, rv);
         spi_host_inst.xfer({8'h80, adr[i % 5], 16'h0000}, 32, rv);
         chk("reg", i < 5 ? 16'h0000 : seed[15:0] & msk[i % 5], rv);
      end
      $display("registers done");
      spi_host_inst.xfer({8'h00, 8'hFE, 16'hA5C3}, 32, rv);
      spi_host_inst.xfer({8'h00, 8'hFE, 16'h5A3C}, 20, rv);
      chk("out", 16'hA5C3, section3_expected_check);
      hw_reset_pin_n <= 1'b0;
      @(posedge clk_sys) hw_reset_pin_n <= 1'b1;
      chk("out", 16'h0000, section3_expected_check);
      $display("abort and pin reset done");
      repeat (200) begin
         seed = xs(seed);
         @(posedge clk_sys) {conv_done_a, conv_done_b, result_read} <= seed[2:0] & seed[5:3];
         @(negedge clk_sys) chk("ready", {15'h0, ~rdy}, {15'h0, data_ready_pin_n});
         rdy = conv_done_a | conv_done_b | (rdy & ~result_read);
      end
      $display("ready done");
      final_report;
   end
endmodule // crc_scratch_register_bank_tb
